// ---- core/mao_alu.sv ----
/*
  Combinational arithmetic unit: add, decimal adjust, increment and
  decrement of one byte, with carry, half carry and zero results.
  Assumes the caller decides which results are written back.
*/
`timescale 1ns/1ns
module mao_alu (
  input  wire mao_pkg::mao_op_type          op_i,
  input  wire logic [mao_pkg::WORD_W-1:0]   working_i,
  input  wire logic [mao_pkg::WORD_W-1:0]   file_i,
  input  wire logic                         carry_i,
  input  wire logic                         half_carry_i,
  output logic      [mao_pkg::WORD_W-1:0]   result_o,
  output logic                              carry_o,
  output logic                              half_carry_o,
  output logic                              zero_o
);
  import mao_pkg::*;

  // One adder path per operation; unused ops pass the file value.
  always_comb begin
    logic [WORD_W:0]   sum;
    logic [4:0]        low_sum;
    logic [WORD_W-1:0] adj;
    sum          = '0;
    low_sum      = '0;
    adj          = ZERO;
    result_o     = file_i;
    carry_o      = carry_i;
    half_carry_o = half_carry_i;
    case (op_i)
      MAO_OP_ADD: begin
        sum          = {1'b0, working_i} + {1'b0, file_i};
        low_sum      = {1'b0, working_i[3:0]} + {1'b0, file_i[3:0]};
        result_o     = sum[WORD_W-1:0];
        carry_o      = sum[WORD_W];
        half_carry_o = low_sum[4];
      end
      MAO_OP_DEC_ADJ: begin
        // Flags of the preceding add, or digits out of BCD range, decide each digit's correction.
        if (half_carry_i || (working_i[3:0] > DIGIT_MAX)) begin
          adj = adj | LOW_ADJ;
        end
        if (carry_i || (working_i > BCD_MAX)) begin
          adj     = adj | HIGH_ADJ;
          carry_o = 1'b1;
        end
        result_o = working_i + adj;
      end
      MAO_OP_DOWN_SKIP, MAO_OP_DOWN: begin
        result_o = file_i - ONE;
      end
      MAO_OP_UP: begin
        result_o = file_i + ONE;
      end
      default: begin
        result_o = file_i;
      end
    endcase
    zero_o = mao_is_zero(result_o);
  end

endmodule : mao_alu

// ---- core/mao_exec.sv ----
/*
  Execution block for decimal adjust, count up, count down, count down
  with skip on zero, and global interrupt enable and disable, together
  with the working register, a 128-byte file and the status flags.
  An operation offered on the op port is taken on the rising edge at
  which op_valid_i and op_ready_o are both high. Its results show on
  the outputs from the next cycle on, and done_o pulses for one cycle
  once the operation has finished.
  A count down with skip whose result is zero holds op_ready_o low for
  one further cycle, the discarded slot, and flags it on skip_nop_o.
  rd_data_o is a registered debug view of the file, one cycle behind
  rd_addr_i, showing the value from before a write on the same edge.

  Assumes one operation is offered at a time on the op port by logic on
  the same clock, and that the fetch unit drops its fetched instruction
  while skip_nop_o is high.
  Decimal adjust relies on the carry and half carry left by the add
  just before it; the block cannot check that order, software must.
  Reset is asynchronous; its release is expected to be clean with
  respect to the clock, which the surrounding reset logic ensures.
*/

`timescale 1ns/1ns
module mao_exec (
  input  wire  logic                          core_clk_i,
  input  wire  logic                          resetn_i,
  input  wire  logic                          op_valid_i,
  output logic                                op_ready_o,
  input  wire  mao_pkg::mao_op_type           op_code_i,
  input  wire  logic [mao_pkg::ADDR_W-1:0]    op_addr_i,
  input  wire  logic                          op_dest_i,
  input  wire  logic [mao_pkg::WORD_W-1:0]    op_data_i,
  input  wire  logic [mao_pkg::ADDR_W-1:0]    rd_addr_i,
  output logic       [mao_pkg::WORD_W-1:0]    rd_data_o,
  output logic       [mao_pkg::WORD_W-1:0]    working_o,
  output logic                                carry_o,
  output logic                                half_carry_o,
  output logic                                zero_o,
  output logic                                irq_enable_o,
  output logic                                skip_nop_o,
  output logic                                done_o
);
  import mao_pkg::*;

  // Every bit of state lives in one struct.
  // The file sits in the struct too, so one register process covers it;
  // the struct is wide, but the next-state copy stays simple.
  typedef struct packed {
    mao_state_type                        state;
    logic [FILE_DEPTH-1:0][WORD_W-1:0]    file;
    logic [WORD_W-1:0]                    working;
    logic                                 carry;
    logic                                 half_carry;
    logic                                 zero;
    logic                                 master_irq_enable;
    logic [WORD_W-1:0]                    rd_data;
    logic                                 done;
  } mao_regs_type;

  mao_regs_type s_reg;
  mao_regs_type s_next;

  // Operand and result wires between the state and the arithmetic unit.
  logic [WORD_W-1:0] file_rd;
  logic [WORD_W-1:0] alu_result;
  logic              alu_carry;
  logic              alu_half_carry;
  logic              alu_zero;
  logic              op_take;

  // File operand read for the operation being offered.
  // The address comes from the op port itself, so a back-to-back op
  // already sees the value that the op before it wrote.
  assign file_rd = s_reg.file[op_addr_i];

  // The offered op is only taken while no skip slot is running.
  // Ready depends on the state only, never on valid, so no loop can
  // form with a fetch unit that waits for ready before it offers.
  assign op_ready_o = (s_reg.state == MAO_ST_RUN);
  assign op_take    = op_valid_i && op_ready_o;

  // Shared arithmetic for add, adjust and the counts; it sees the offered
  // opcode directly, since its result is only used when the op is taken.
  mao_alu u_alu (
    .op_i         (op_code_i),
    .working_i    (s_reg.working),
    .file_i       (file_rd),
    .carry_i      (s_reg.carry),
    .half_carry_i (s_reg.half_carry),
    .result_o     (alu_result),
    .carry_o      (alu_carry),
    .half_carry_o (alu_half_carry),
    .zero_o       (alu_zero)
  );

  // Next-state logic: execute the taken op, then run any skip slot.
  // The read-back register follows rd_addr_i every cycle, and done is a
  // one-cycle pulse that is cleared unless a branch finishes an op.
  always_comb begin
    s_next         = s_reg;
    s_next.done    = 1'b0;
    s_next.rd_data = s_reg.file[rd_addr_i];
    case (s_reg.state)
      MAO_ST_RUN: begin
        if (op_take) begin
          s_next.done = 1'b1;
          case (op_code_i)
            MAO_OP_ADD: begin
              // Sum goes per destination; flags feed a later adjust.
              if (op_dest_i == DEST_FILE) begin
                s_next.file[op_addr_i] = alu_result;
              end else begin
                s_next.working = alu_result;
              end
              s_next.carry      = alu_carry;
              s_next.half_carry = alu_half_carry;
              s_next.zero       = alu_zero;
            end
            MAO_OP_DEC_ADJ: begin
              // Result back to working, only carry is touched.
              // Half carry and zero keep what the add left behind.
              s_next.working = alu_result;
              s_next.carry   = alu_carry;
            end
            MAO_OP_DOWN_SKIP: begin
              // No flag changes here, even when the result is zero.
              if (op_dest_i == DEST_FILE) begin
                s_next.file[op_addr_i] = alu_result;
              end else begin
                s_next.working = alu_result;
              end
              if (alu_zero) begin
                // Hold off the next op for the discarded slot.
                // Ready drops next cycle; done waits for the slot.
                s_next.state = MAO_ST_SKIP;
                s_next.done  = 1'b0;
              end
            end
            MAO_OP_DOWN, MAO_OP_UP: begin
              // One cycle; zero tracks the 8-bit result.
              if (op_dest_i == DEST_FILE) begin
                s_next.file[op_addr_i] = alu_result;
              end else begin
                s_next.working = alu_result;
              end
              s_next.zero = alu_zero;
            end
            MAO_OP_IRQ_OFF: begin
              // Takes effect from the next cycle; a request already
              // being taken on this edge is the interrupt logic's task.
              s_next.master_irq_enable = 1'b0;
            end
            MAO_OP_IRQ_ON: begin
              // Requests are let through from the next cycle on.
              s_next.master_irq_enable = 1'b1;
            end
            // Loads feed the block its operands; they touch no flag.
            MAO_OP_LOAD_W: begin
              s_next.working = op_data_i;
            end
            MAO_OP_LOAD_F: begin
              s_next.file[op_addr_i] = op_data_i;
            end
            default: begin
              // Unused codes act as a no-op but still report done.
              s_next.done = 1'b1;
            end
          endcase
        end
      end
      MAO_ST_SKIP: begin
        // The fetched instruction is dropped; a no-op fills the slot.
        // Nothing is written in this cycle, so the state stays as the
        // count down with skip left it.
        s_next.state = MAO_ST_RUN;
        s_next.done  = 1'b1;
      end
      default: begin
        // Unused state codes fall back to the run state.
        s_next.state = MAO_ST_RUN;
      end
    endcase
  end

  // State register; reset loads constants only.
  // The file is cleared too, so the read-back port never shows unknowns.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_reg                   <= '0;
      s_reg.state             <= MAO_ST_RUN;
      s_reg.file              <= {FILE_DEPTH{FILE_RST}};
      s_reg.working           <= WORKING_RST;
      s_reg.carry             <= FLAG_RST;
      s_reg.half_carry        <= FLAG_RST;
      s_reg.zero              <= FLAG_RST;
      s_reg.master_irq_enable <= IRQ_EN_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state, except the handshake.
  // Skip is decoded from one state compare rather than kept in its own
  // flop, which costs a gate but can never disagree with ready.
  assign rd_data_o    = s_reg.rd_data;
  assign working_o    = s_reg.working;
  assign carry_o      = s_reg.carry;
  assign half_carry_o = s_reg.half_carry;
  assign zero_o       = s_reg.zero;
  assign irq_enable_o = s_reg.master_irq_enable;
  assign skip_nop_o   = (s_reg.state == MAO_ST_SKIP); // Decoded, no glitch.
  assign done_o       = s_reg.done;

endmodule : mao_exec

// ---- core/mao_pkg.sv ----
/*
  Shared constants, types and helper functions for the arithmetic and
  interrupt-enable execution block of an 8-bit core.
  Assumes the fetch logic issues one operation at a time and honours the
  ready handshake of the execution block.
*/
package mao_pkg;

  // Data path and file geometry.
  localparam int WORD_W     = 8;
  localparam int FILE_DEPTH = 128;
  localparam int ADDR_W     = 7;

  // Destination select values.
  localparam logic DEST_WORKING = 1'b0;
  localparam logic DEST_FILE    = 1'b1;

  // Decimal adjust and count constants.
  localparam logic [3:0]        DIGIT_MAX = 4'h9;
  localparam logic [WORD_W-1:0] BCD_MAX   = 8'h99;
  localparam logic [WORD_W-1:0] LOW_ADJ   = 8'h06;
  localparam logic [WORD_W-1:0] HIGH_ADJ  = 8'h60;
  localparam logic [WORD_W-1:0] ONE       = 8'h01;
  localparam logic [WORD_W-1:0] ZERO      = 8'h00;

  // Reset values of the architectural state.
  localparam logic [WORD_W-1:0] WORKING_RST = 8'h00;
  localparam logic [WORD_W-1:0] FILE_RST    = 8'h00;
  localparam logic              FLAG_RST    = 1'b0;
  localparam logic              IRQ_EN_RST  = 1'b0;

  // Instruction cycle counts.
  localparam int CYCLES_PLAIN = 1;
  localparam int CYCLES_SKIP  = 2;

  // Operations accepted by the execution block.
  typedef enum logic [3:0] {
    MAO_OP_NOP       = 4'h0,
    MAO_OP_ADD       = 4'h1,
    MAO_OP_DEC_ADJ   = 4'h2,
    MAO_OP_DOWN_SKIP = 4'h3,
    MAO_OP_DOWN      = 4'h4,
    MAO_OP_UP        = 4'h5,
    MAO_OP_IRQ_OFF   = 4'h6,
    MAO_OP_IRQ_ON    = 4'h7,
    MAO_OP_LOAD_W    = 4'h8,
    MAO_OP_LOAD_F    = 4'h9
  } mao_op_type;

  // Sequencer states, Gray coded along the skip path.
  typedef enum logic [1:0] {
    MAO_ST_RUN  = 2'b00,
    MAO_ST_SKIP = 2'b01
  } mao_state_type;

  // True when an 8-bit value is zero.
  function automatic logic mao_is_zero(input logic [WORD_W-1:0] value);
    return (value == ZERO);
  endfunction : mao_is_zero

endpackage : mao_pkg

// ---- verif/mao_exec_sva.sv ----
/* Checker for the execution block's op port and flags.
   Assumes it is bound to every mao_exec instance. */
`timescale 1ns/1ns
module mao_exec_chk (
  input wire logic                core_clk_i,
  input wire logic                resetn_i,
  input wire logic                op_valid_i,
  input wire logic                op_ready_o,
  input wire mao_pkg::mao_op_type op_code_i,
  input wire logic                op_dest_i,
  input wire logic [7:0]          working_o,
  input wire logic                carry_o,
  input wire logic                half_carry_o,
  input wire logic                zero_o,
  input wire logic                irq_enable_o,
  input wire logic                skip_nop_o,
  input wire logic                done_o
);
  import mao_pkg::*;
  // An op counts only on an edge where the block is ready.
  wire tk = op_valid_i && op_ready_o;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  chk_skip_refused: assert property (skip_nop_o |-> !op_ready_o)
    else $error("ready high in skip slot");
  chk_skip_len: assert property (skip_nop_o |=> !skip_nop_o && done_o)
    else $error("skip slot not one cycle");
  chk_skip_zero: assert property (tk && op_code_i == MAO_OP_DOWN_SKIP
    && !op_dest_i |=> skip_nop_o == (working_o == ZERO))
    else $error("skip does not follow zero result");
  chk_skip_flags: assert property (tk && op_code_i == MAO_OP_DOWN_SKIP
    |=> $stable({carry_o, half_carry_o, zero_o}))
    else $error("down skip changed a flag");
  chk_plain_done: assert property (tk && op_code_i != MAO_OP_DOWN_SKIP
    |=> done_o && !skip_nop_o)
    else $error("plain op not done in one cycle");
  chk_count_zero: assert property (tk && !op_dest_i &&
    (op_code_i == MAO_OP_UP || op_code_i == MAO_OP_DOWN)
    |=> zero_o == (working_o == ZERO))
    else $error("zero flag wrong after count");
  chk_irq_off: assert property (tk && op_code_i == MAO_OP_IRQ_OFF
    |=> !irq_enable_o) else $error("enable not cleared");
  chk_irq_on: assert property (tk && op_code_i == MAO_OP_IRQ_ON
    |=> irq_enable_o) else $error("enable not set");
  chk_adj_flags: assert property (tk && op_code_i == MAO_OP_DEC_ADJ
    |=> $stable({half_carry_o, zero_o}) && (carry_o || !$past(carry_o)))
    else $error("adjust touched a flag other than carry");
  // Main scenarios reached.
  cover property (tk && op_code_i == MAO_OP_DOWN_SKIP ##1 skip_nop_o);
  cover property (tk && op_code_i == MAO_OP_DEC_ADJ);
  cover property (tk && op_code_i == MAO_OP_IRQ_ON);
endmodule : mao_exec_chk
bind mao_exec mao_exec_chk u_chk (.core_clk_i(core_clk_i),
  .resetn_i(resetn_i), .op_valid_i(op_valid_i), .op_ready_o(op_ready_o),
  .op_code_i(op_code_i), .op_dest_i(op_dest_i), .working_o(working_o),
  .carry_o(carry_o), .half_carry_o(half_carry_o), .zero_o(zero_o),
  .irq_enable_o(irq_enable_o), .skip_nop_o(skip_nop_o), .done_o(done_o));

// ---- verif/mao_exec_tb.sv ----
/* Self-checking bench for mao_exec with a reference model.
   Assumes the checker file is compiled alongside. */
`timescale 1ns/1ns
module mao_exec_tb;
  import mao_pkg::*;
  logic       clk = 0, rstn = 0, v = 0, dest = 0;
  mao_op_type code = MAO_OP_NOP;
  logic [6:0] addr = 0, rda = 0;
  logic [7:0] data = 0, rdd, w_o, w, f [128];
  logic       rdy, c_o, h_o, z_o, ie_o, sk_o, dn_o, c, h, z, ie, sk, dn;
  integer     errors = 0, n_checks = 0, seed = 32'h9a674029, i, r;
  always #10 clk = ~clk;
  mao_exec u_dut (.core_clk_i(clk), .resetn_i(rstn), .op_valid_i(v),
    .op_ready_o(rdy), .op_code_i(code), .op_addr_i(addr), .op_dest_i(dest),
    .op_data_i(data), .rd_addr_i(rda), .rd_data_o(rdd), .working_o(w_o),
    .carry_o(c_o), .half_carry_o(h_o), .zero_o(z_o), .irq_enable_o(ie_o),
    .skip_nop_o(sk_o), .done_o(dn_o));
  task cmp8(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp8
  task cmp1(input logic g, input logic e);
    cmp8({7'h0, g}, {7'h0, e});
  endtask : cmp1
  task tally_and_finish;
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  // Compares working, carry, half carry, zero, enable, skip and done with the model.
  task chk_state;
    cmp8(w_o, w);
    cmp1(c_o, c);
    cmp1(h_o, h);
    cmp1(z_o, z);
    cmp1(ie_o, ie);
    cmp1(sk_o, sk);
    cmp1(dn_o, dn);
  endtask : chk_state
  task put(input logic [7:0] x, input logic [6:0] a, input logic d);
    if (d) f[a] = x;
    else w = x;
  endtask : put
  // Offers one op and holds it until taken; the model then follows.
  task op(input mao_op_type k, input logic [6:0] a, input logic d,
          input logic [7:0] x);
    logic [8:0] s;
    @(negedge clk);
    chk_state;
    v = 1; code = k; addr = a; dest = d; data = x;
    while (rdy !== 1'b1) @(negedge clk);
    @(posedge clk);
    dn = 1; sk = 0;
    case (k)
      MAO_OP_ADD: begin
        s = {1'b0, w} + f[a]; h = (w[3:0] + f[a][3:0]) > 15;
        c = s[8]; z = s[7:0] == 0; put(s[7:0], a, d);
      end
      MAO_OP_DEC_ADJ: begin
        s = {1'b0, w};
        if (h || w[3:0] > 9) s = s + 6;
        if (c || w > 8'h99) begin s = s + 8'h60; c = 1; end
        w = s[7:0];
      end
      MAO_OP_DOWN_SKIP: begin
        s = f[a] - 1; put(s[7:0], a, d); sk = s[7:0] == 0; dn = !sk;
      end
      MAO_OP_DOWN: begin s = f[a] - 1; z = s[7:0] == 0; put(s[7:0], a, d); end
      MAO_OP_UP: begin s = f[a] + 1; z = s[7:0] == 0; put(s[7:0], a, d); end
      MAO_OP_IRQ_OFF: ie = 0;
      MAO_OP_IRQ_ON: ie = 1;
      MAO_OP_LOAD_W: w = x;
      MAO_OP_LOAD_F: f[a] = x;
      default: ;
    endcase
  endtask : op
  // Idles the port and reads the whole file back.
  task sweep;
    @(negedge clk);
    chk_state;
    v = 0; dn = 0; sk = 0;
    for (i = 0; i < 128; i++) begin
      rda = i;
      @(negedge clk);
      cmp8(rdd, f[i]);
    end
    cmp1(rdy, 1'b1);
  endtask : sweep
  task rst;
    @(negedge clk);
    rstn = 0; v = 0;
    for (i = 0; i < 128; i++) f[i] = 0;
    w = 0; c = 0; h = 0; z = 0; ie = 0; sk = 0; dn = 0;
    repeat (4) @(negedge clk);
    rstn = 1;
  endtask : rst
  // Corners first, then random ops, a mid-run reset and readback.
  initial begin
    rst;
    op(MAO_OP_LOAD_W, 0, 0, 8'h28); op(MAO_OP_LOAD_F, 1, 0, 8'h25);
    op(MAO_OP_IRQ_OFF, 0, 0, 0); op(MAO_OP_ADD, 1, 0, 0);
    op(MAO_OP_DEC_ADJ, 0, 0, 0);
    cmp8(w, 8'h53);
    cmp1(c, 1'b0);
    op(MAO_OP_IRQ_ON, 0, 0, 0);
    op(MAO_OP_LOAD_F, 127, 0, 8'hff); op(MAO_OP_UP, 127, 1, 0);
    op(MAO_OP_DOWN, 127, 1, 0); op(MAO_OP_LOAD_F, 3, 0, 1);
    op(MAO_OP_DOWN_SKIP, 3, 1, 0); op(MAO_OP_DOWN_SKIP, 3, 0, 0);
    sweep;
    repeat (400) begin
      r = $random(seed);
      op(mao_op_type'(r[3:0] % 10), r[4] ? 7'd127 - r[7:5] : r[7:5], r[8],
         r[9] ? r[23:16] : {6'h0, r[11:10]});
    end
    sweep;
    rst;
    sweep;
    tally_and_finish;
  end
  // Cuts a hang short well after the expected run length.
  initial begin
    #400000;
    errors++;
    tally_and_finish;
  end
endmodule : mao_exec_tb
